//--- logic/dcs_adc_defs.vh
// constants for the two-input converter sequencer and its serial port
// Notes on behaviour
// RULE1: track input for first three clocks
// RULE2: hold and convert over next thirteen clocks
// RULE3: result MSB first, first bit clock five
// RULE4: host frames sixteen-edge multiples with select
// RULE5: result output enabled only while select low
// RULE6: power down when deselected and between conversions
// RULE7: retrack after sixteenth rise, hold fourth fall
// RULE8: serial clock ignored while select high
// RULE9: select fall with clock low is fall
// RULE10: clock high at select fall waits
// RULE11: first eight rising edges form control word
// RULE12: channel address applies to next conversion
// RULE13: sample frozen on fourth falling edge
// RULE14: each conversion spans exactly sixteen clocks
// RULE15: address bits five-three, low bit picks input
// RULE16: host never sets middle address bit
// RULE17: first conversion after reset samples input a
// RULE18: simultaneous fall: next rise is first
// RULE19: bits launched on falls five through sixteen
// RULE20: control word captured MSB first
// RULE21: output low during first four clocks
`ifndef DCS_ADC_DEFS_VH
`define DCS_ADC_DEFS_VH

// ------------------------------------------------------------
// conversion framing
// ------------------------------------------------------------
`define DCS_TRACK_CLKS     5'h03
`define DCS_CONV_CLKS      5'h0d
`define DCS_GROUP_CLKS     5'h10
`define DCS_HOLD_EDGE      5'h04
`define DCS_FIRST_BIT_EDGE 5'h05
`define DCS_CMD_BITS       5'h08

// ------------------------------------------------------------
// control word fields and widths
// ------------------------------------------------------------
`define DCS_ADDR_TOP_BIT   5
`define DCS_ADDR_MID_BIT   4
`define DCS_ADDR_LOW_BIT   3
`define DCS_RES_W          12
`define DCS_CMD_W          8

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DCS_MUX_RESET      1'h0
`define DCS_CMD_RESET      8'h00

`endif

//--- logic/dcs_adc_sequencer.v
// conversion sequencer and serial port of the two-input sampling converter
`timescale 1ns/10ps
`include "dcs_adc_defs.vh"

module dcs_adc_sequencer
(
  input  wire        sys_clk_i,
  input  wire        reset_i,
  input  wire        ce_i,
  input  wire        cs_n_i,
  input  wire        sclk_i,
  input  wire        din_i,
  input  wire [11:0] analog_input_a_i,
  input  wire [11:0] analog_input_b_i,
  output wire        dout_o,
  output wire        dout_oe_o,
  output wire        track_o,
  output wire        hold_o,
  output wire        power_down_o,
  output wire        mux_sel_o,
  output wire [7:0]  ctrl_word_o,
  output wire        ctrl_strobe_o
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [1:0] ST_OFF   = 2'h0;
  localparam [1:0] ST_TRACK = 2'h1;
  localparam [1:0] ST_HOLD  = 2'h2;
  localparam [1:0] ST_GAP   = 2'h3;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  wire [2:0]            pin_in;
  reg  [2:0]            pin_meta_r;
  reg  [2:0]            pin_sync_r;
  wire                  cs_n_s;
  wire                  sclk_s;
  wire                  din_s;
  wire                  gclk;
  reg                   gclk_q_r;
  wire                  sclk_fall;
  wire                  sclk_rise;

  reg  [1:0]            state_r;
  reg  [1:0]            state_nxt;
  reg  [4:0]            fall_cnt_r;
  reg  [4:0]            fall_nxt;
  reg  [4:0]            rise_cnt_r;
  reg  [4:0]            rise_nxt;
  reg  [7:0]            cmd_r;
  reg  [7:0]            cmd_nxt;
  reg  [7:0]            ctrl_r;
  reg  [7:0]            ctrl_nxt;
  reg                   strobe_r;
  reg                   strobe_nxt;
  reg                   pend_r;
  reg                   pend_nxt;
  reg                   mux_r;
  reg                   mux_nxt;
  reg  [11:0]           samp_r;
  reg  [11:0]           samp_nxt;
  reg                   dout_r;
  reg                   dout_nxt;
  reg                   dout_oe_r;
  reg                   track_r;
  reg                   hold_r;
  reg                   pdown_r;
  reg                   track_nxt;
  reg                   hold_nxt;
  reg                   pdown_nxt;
  reg  [4:0]            bit_idx;
  reg  [7:0]            cmd_shift;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // two clocks of sync plus one for the edge detector: each serial
  // clock edge acts three system clocks after it reaches the pin, and
  // a phase of one system clock is still seen
  assign pin_in = {din_i, sclk_i, cs_n_i};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_sync
      always @(posedge sys_clk_i)
      begin
        if (reset_i)
        begin
          pin_meta_r[g] <= 1'b1;
          pin_sync_r[g] <= 1'b1;
        end
        else if (ce_i)
        begin
          pin_meta_r[g] <= pin_in[g];
          pin_sync_r[g] <= pin_meta_r[g];
        end
      end
    end
  endgenerate

  assign cs_n_s = pin_sync_r[0];
  assign sclk_s = pin_sync_r[1];
  assign din_s  = pin_sync_r[2];

  // ------------------------------------------------------------
  // internal clock gating
  // ------------------------------------------------------------
  // held high while deselected: a select fall with the clock low
  // then reads as a falling edge, a high clock waits for its fall
  assign gclk = sclk_s | cs_n_s;                        // [RULE8] [RULE9] [RULE10]

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
      gclk_q_r <= 1'b1;
    else if (ce_i)
      gclk_q_r <= gclk;
  end

  assign sclk_fall = gclk_q_r & ~gclk;
  // the rise caused by select going high is no clock edge
  assign sclk_rise = ~gclk_q_r & gclk & ~cs_n_s;        // [RULE8]

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always @*
  begin
    state_nxt  = state_r;
    fall_nxt   = fall_cnt_r;
    rise_nxt   = rise_cnt_r;
    cmd_nxt    = cmd_r;
    ctrl_nxt   = ctrl_r;
    strobe_nxt = 1'b0;
    pend_nxt   = pend_r;
    mux_nxt    = mux_r;
    samp_nxt   = samp_r;
    dout_nxt   = dout_r;
    bit_idx    = 5'h00;
    cmd_shift  = {cmd_r[6:0], din_s};                   // [RULE20]

    if (cs_n_s)
    begin
      // frame closed: core idles, half-done conversion is dropped
      state_nxt = ST_OFF;                               // [RULE6]
      fall_nxt  = 5'h00;
      rise_nxt  = 5'h00;
      dout_nxt  = 1'b0;
    end
    else
    begin
      if (sclk_fall)
      begin
        case (state_r)
          ST_OFF, ST_GAP:
          begin
            state_nxt = ST_TRACK;                       // [RULE1] [RULE7] [RULE9]
            fall_nxt  = 5'h01;
          end
          ST_TRACK, ST_HOLD:
            fall_nxt = fall_cnt_r + 5'h01;
          default:
            state_nxt = ST_OFF;
        endcase

        if (fall_nxt == `DCS_HOLD_EDGE)
        begin
          state_nxt = ST_HOLD;                          // [RULE2] [RULE7] [RULE13]
          samp_nxt  = mux_r ? analog_input_b_i : analog_input_a_i;
        end

        // fall n launches bit 16-n; earlier falls keep the line low
        if (fall_nxt >= `DCS_FIRST_BIT_EDGE && fall_nxt <= `DCS_GROUP_CLKS)
        begin
          bit_idx  = `DCS_GROUP_CLKS - fall_nxt;
          dout_nxt = samp_r[bit_idx[3:0]];              // [RULE3] [RULE19]
        end
        else
          dout_nxt = 1'b0;                              // [RULE21]
      end

      if (sclk_rise && (state_r == ST_TRACK || state_r == ST_HOLD))
      begin
        // first rise after entering track is the first command bit
        rise_nxt = rise_cnt_r + 5'h01;                  // [RULE18]
        if (rise_cnt_r < `DCS_CMD_BITS)
          cmd_nxt = cmd_shift;                          // [RULE11]
        if (rise_nxt == `DCS_CMD_BITS)
        begin
          ctrl_nxt   = cmd_shift;
          strobe_nxt = 1'b1;
          // only the low address bit steers the mux; the top bit
          // and the middle bit are both ignored, whatever their value
          pend_nxt   = cmd_shift[`DCS_ADDR_LOW_BIT];    // [RULE15] [RULE16]
        end
        // a cut frame keeps the pending address but never applies it
        if (rise_nxt == `DCS_GROUP_CLKS)
        begin
          state_nxt = ST_GAP;                           // [RULE6] [RULE14]
          rise_nxt  = 5'h00;
          mux_nxt   = pend_r;                           // [RULE12]
        end
      end
    end
  end

  // ------------------------------------------------------------
  // sequencer registers
  // ------------------------------------------------------------
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state_r    <= ST_OFF;
      fall_cnt_r <= 5'h00;
      rise_cnt_r <= 5'h00;
      cmd_r      <= `DCS_CMD_RESET;
      ctrl_r     <= `DCS_CMD_RESET;
      strobe_r   <= 1'b0;
      pend_r     <= `DCS_MUX_RESET;
      mux_r      <= `DCS_MUX_RESET;                     // [RULE17]
      samp_r     <= 12'h000;
      dout_r     <= 1'b0;
    end
    else if (ce_i)
    begin
      state_r    <= state_nxt;
      fall_cnt_r <= fall_nxt;
      rise_cnt_r <= rise_nxt;
      cmd_r      <= cmd_nxt;
      ctrl_r     <= ctrl_nxt;
      strobe_r   <= strobe_nxt;
      pend_r     <= pend_nxt;
      mux_r      <= mux_nxt;
      samp_r     <= samp_nxt;
      dout_r     <= dout_nxt;
    end
  end

  // ------------------------------------------------------------
  // status decode
  // ------------------------------------------------------------
  // unused codes fall back to powered down
  always @*
  begin
    track_nxt = 1'b0;
    hold_nxt  = 1'b0;
    pdown_nxt = 1'b1;
    case (state_nxt)
      ST_TRACK:
      begin
        track_nxt = 1'b1;                               // [RULE1]
        pdown_nxt = 1'b0;
      end
      ST_HOLD:
      begin
        hold_nxt  = 1'b1;                               // [RULE2]
        pdown_nxt = 1'b0;
      end
      ST_OFF, ST_GAP:
        pdown_nxt = 1'b1;                               // [RULE6]
      default:
        pdown_nxt = 1'b1;
    endcase
  end

  // ------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------
  // registered from next state so status and state change together
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      dout_oe_r <= 1'b0;
      track_r   <= 1'b0;
      hold_r    <= 1'b0;
      pdown_r   <= 1'b1;
    end
    else if (ce_i)
    begin
      dout_oe_r <= ~cs_n_s;                             // [RULE5]
      track_r   <= track_nxt;
      hold_r    <= hold_nxt;
      pdown_r   <= pdown_nxt;                           // [RULE6]
    end
  end

  assign dout_o        = dout_r;
  assign dout_oe_o     = dout_oe_r;
  assign track_o       = track_r;
  assign hold_o        = hold_r;
  assign power_down_o  = pdown_r;
  assign mux_sel_o     = mux_r;
  assign ctrl_word_o   = ctrl_r;
  assign ctrl_strobe_o = strobe_r;

endmodule

//--- testbench/dcs_adc_asserts.sv
// port checker for the converter sequencer
`timescale 1ns/10ps
module dcs_adc_asserts
(
  input logic       sys_clk_i,
  input logic       reset_i,
  input logic       cs_n_i,
  input logic       dout_o,
  input logic       dout_oe_o,
  input logic       track_o,
  input logic       hold_o,
  input logic       power_down_o,
  input logic       mux_sel_o,
  input logic [7:0] ctrl_word_o,
  input logic       ctrl_strobe_o
);
  // --------------------------------
  // port relations
  // --------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  AST_OE_FOLLOWS: assert property (dout_oe_o == !$past(cs_n_i, 3))
    else $error("enable not following select");
  AST_OFF_QUIET: assert property (cs_n_i [*5] |-> !dout_oe_o && !dout_o && !track_o && !hold_o && power_down_o)
    else $error("activity while deselected");
  AST_TRACK_ONLY: assert property (track_o |-> !hold_o && !power_down_o && !dout_o)
    else $error("track overlaps another state");
  AST_HOLD_AFTER_TRACK: assert property ($rose(hold_o) |-> $past(track_o))
    else $error("hold without tracking");
  AST_HOLD_END: assert property ($fell(hold_o) |-> power_down_o)
    else $error("hold ended outside gap");
  AST_TRACK_START: assert property ($rose(track_o) |-> $past(power_down_o))
    else $error("track not from gap");
  AST_WORD_STROBE: assert property ($changed(ctrl_word_o) |-> ctrl_strobe_o)
    else $error("word changed without strobe");
  AST_MUX_AT_END: assert property ($changed(mux_sel_o) |-> $rose(power_down_o))
    else $error("channel switched mid conversion");
  AST_STROBE_PULSE: assert property (ctrl_strobe_o |=> !ctrl_strobe_o)
    else $error("strobe longer than one cycle");
endmodule
bind dcs_adc_sequencer dcs_adc_asserts i_chk
(
  .sys_clk_i, .reset_i, .cs_n_i, .dout_o, .dout_oe_o, .track_o,
  .hold_o, .power_down_o, .mux_sel_o, .ctrl_word_o, .ctrl_strobe_o
);

//--- testbench/dcs_host_model.sv
// serial master model: select, clock, command out, result in
`timescale 1ns/10ps
module dcs_host_model
(
  input  logic sys_clk_i,
  input  logic dout_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  // each clock phase well above the three-cycle sync delay
  localparam int HALF = 5;
  logic [31:0] rx_r;
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o  = 1'b0;
    rx_r   = 32'h0;
  end
  // --------------------------------
  // one frame; clks below a 16 multiple cuts it short
  // --------------------------------
  task automatic frame(input logic [15:0] cmds, input bit rest_hi, input int clks);
    int k;
    sclk_o <= rest_hi;
    repeat (HALF) @(posedge sys_clk_i);
    cs_n_o <= 1'b0;
    if (rest_hi)
      repeat (HALF) @(posedge sys_clk_i);
    for (k = 0; k < clks; k++)
    begin
      sclk_o <= 1'b0;
      // toggling after the command so stale bits never pass
      din_o <= (k % 16 < 8) ? cmds[15 - (k / 16) * 8 - k % 16] : ~din_o;
      repeat (HALF) @(posedge sys_clk_i);
      sclk_o <= 1'b1;
      rx_r <= {rx_r[30:0], dout_i};
      repeat (HALF) @(posedge sys_clk_i);
    end
    cs_n_o <= 1'b1;
    sclk_o <= rest_hi;
  endtask
endmodule

//--- testbench/dcs_adc_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
module testbench;
  localparam logic [11:0] VAL_A = 12'ha5c;
  localparam logic [11:0] VAL_B = 12'h3c9;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       cs_n, sclk, din, dout, oe, trk, hld, pd, mux, stb;
  logic [7:0] cw;
  int         err_total = 0;
  int         checks_done = 0;
  int         cyc = 0;
  logic       trk_q = 1'b0;
  logic       hld_q = 1'b0;
  logic       gpin_q = 1'b1;
  int         trk_falls = 0;
  int         hold_falls = 0;
  int         stb_seen = 0;
  dcs_adc_sequencer i_dut
  (
    .sys_clk_i(clk), .reset_i(rst), .ce_i(1'b1), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
    .analog_input_a_i(VAL_A), .analog_input_b_i(VAL_B), .dout_o(dout), .dout_oe_o(oe),
    .track_o(trk), .hold_o(hld), .power_down_o(pd), .mux_sel_o(mux), .ctrl_word_o(cw),
    .ctrl_strobe_o(stb)
  );
  dcs_host_model i_host
  (
    .sys_clk_i(clk), .dout_i(oe ? dout : ~dout), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din)
  );
  initial
    forever #12.5 clk = ~clk;
  // --------------------------------
  // checking and closing
  // --------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      final_report;
    end
  end
  // pin-level falls of the gated clock counted while tracking
  always @(posedge clk)
  begin
    gpin_q <= sclk | cs_n;
    trk_q  <= trk;
    hld_q  <= hld;
    if (!trk)
      trk_falls <= 0;
    else if (gpin_q && !(sclk | cs_n))
      trk_falls <= trk_falls + 1;
    if (hld && !hld_q)
      hold_falls <= trk_falls;
    if (stb)
      stb_seen <= stb_seen + 1;
  end
  // --------------------------------
  // scenarios
  // --------------------------------
  task t_reset;
    chk({pd, mux, oe, trk, hld, dout, stb}, 16'h0040);
    chk(cw, 16'h0000);
  endtask
  task t_single;
    i_host.frame(16'h0800, 1'b0, 16);
    repeat (4) @(posedge clk);
    chk(i_host.rx_r[15:0], {4'h0, VAL_A});
    chk(cw, 16'h0008);
    chk({oe, pd, mux}, 16'h0003);
    chk(hold_falls[15:0], 16'h0003);
    chk(stb_seen[15:0], 16'h0001);
  endtask
  task t_multi;
    i_host.frame(16'he72f, 1'b1, 32);
    repeat (4) @(posedge clk);
    chk(i_host.rx_r[31:16], {4'h0, VAL_B});
    chk(i_host.rx_r[15:0], {4'h0, VAL_A});
    chk({cw, 7'h00, mux}, 16'h2f01);
    chk(hold_falls[15:0], 16'h0003);
    chk(stb_seen[15:0], 16'h0003);
  endtask
  task t_cut;
    i_host.frame(16'h0000, 1'b0, 6);
    repeat (4) @(posedge clk);
    chk({cw, 7'h00, mux}, 16'h2f01);
    chk(stb_seen[15:0], 16'h0003);
    i_host.frame(16'h0000, 1'b0, 16);
    repeat (4) @(posedge clk);
    chk(i_host.rx_r[15:0], {4'h0, VAL_B});
    chk({cw, 7'h00, mux}, 16'h0000);
    chk(stb_seen[15:0], 16'h0004);
    chk(hold_falls[15:0], 16'h0003);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_single;
    t_multi;
    t_cut;
    final_report;
  end
endmodule
